// ### rtl/servo_torque_limit_select.v
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "torque_limit_regs.vh"
module servo_torque_limit_select (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Terminals
  input wire forward_clamp_input,
  input wire reverse_clamp_input,
  input wire [15:0] analog_level,
  output reg torque_limited_output,
  // Torque loop
  input wire [15:0] torque_request,
  output reg [15:0] torque_command_q,
  output wire [15:0] fwd_limit,
  output wire [15:0] rev_limit,
  // Pulse sources
  input wire [15:0] low_pulse_count,
  input wire [15:0] high_pulse_count,
  input wire [15:0] int_pulse_count,
  output wire [15:0] pulse_cmd,
  output reg pulse_mode_q,
  output reg int_pos_mode_q,
  // Interrupt
  output wire irq
);

  // ----------------------------------------------------------
  // Settings
  // ----------------------------------------------------------
  reg [15:0] forward_torque_ceiling_q;
  reg [15:0] reverse_torque_ceiling_q;
  reg analog_limit_enable_q;
  reg [15:0] target_torque_band_q;
  reg [15:0] torque_filter_freq_q;
  reg [15:0] internal_torque_ceiling_q;
  reg [15:0] analog_torque_gain_q;
  reg [3:0] control_mode_select_q;
  reg [2:0] pulse_source_select_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_en_q;
  reg mode_prev_q;

  // Bus strobes: a request is seen one edge before ack, a write lands with ack
  wire req_new = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_en = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire rd_en = req_new & ~wb_we_i;

  // Byte-lane merge of a 16-bit field
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] dat;
    input [3:0] sel;
    begin
      merge16[7:0] = sel[0] ? dat[7:0] : old[7:0];
      merge16[15:8] = sel[1] ? dat[15:8] : old[15:8];
    end
  endfunction

  // Clamp to the allowed ceiling range
  function [15:0] clip_ceil;
    input [15:0] v;
    begin
      clip_ceil = (v > `CEIL_MAX) ? `CEIL_MAX : v;
    end
  endfunction

  // Clamp a filter setting into its legal range
  function [15:0] clip_filt;
    input [15:0] v;
    begin
      if (v < `FILT_MIN) begin
        clip_filt = `FILT_MIN;
      end else if (v > `FILT_MAX) begin
        clip_filt = `FILT_MAX;
      end else begin
        clip_filt = v;
      end
    end
  endfunction

  // Zero-extend a 16-bit field to a bus word
  function [31:0] zext16;
    input [15:0] v;
    begin
      zext16 = {16'h0000, v};
    end
  endfunction

  // ----------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------
  // Settings, stored at the edge where the master sees ack
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      forward_torque_ceiling_q <= `RST_FWD_CEIL;
      reverse_torque_ceiling_q <= `RST_REV_CEIL;
      analog_limit_enable_q <= 1'b0;
      target_torque_band_q <= `RST_BAND;
      torque_filter_freq_q <= `RST_FILT;
      internal_torque_ceiling_q <= `RST_INT_CEIL;
      analog_torque_gain_q <= `RST_GAIN;
      control_mode_select_q <= 4'h0;
      pulse_source_select_q <= 3'h0;
      irq_en_q <= 3'h0;
    end else if (wr_en) begin
      case (wb_adr_i)
        `OFS_FWD_CEIL: begin
          forward_torque_ceiling_q <= clip_ceil(merge16(forward_torque_ceiling_q, wb_dat_i, wb_sel_i));
        end
        `OFS_REV_CEIL: begin
          reverse_torque_ceiling_q <= clip_ceil(merge16(reverse_torque_ceiling_q, wb_dat_i, wb_sel_i));
        end
        `OFS_ANA_EN: if (wb_sel_i[0]) begin
          analog_limit_enable_q <= wb_dat_i[0];
        end
        `OFS_BAND: begin
          target_torque_band_q <= merge16(target_torque_band_q, wb_dat_i, wb_sel_i);
        end
        `OFS_FILT: begin
          torque_filter_freq_q <= clip_filt(merge16(torque_filter_freq_q, wb_dat_i, wb_sel_i));
        end
        `OFS_INT_CEIL: begin
          internal_torque_ceiling_q <= clip_ceil(merge16(internal_torque_ceiling_q, wb_dat_i, wb_sel_i));
        end
        `OFS_ANA_GAIN: begin
          analog_torque_gain_q <= merge16(analog_torque_gain_q, wb_dat_i, wb_sel_i);
        end
        `OFS_MODE: if (wb_sel_i[0]) begin
          control_mode_select_q <= wb_dat_i[3:0];
        end
        `OFS_PSRC: if (wb_sel_i[0]) begin
          pulse_source_select_q <= wb_dat_i[2:0];
        end
        `OFS_IRQ_EN: if (wb_sel_i[0]) begin
          irq_en_q <= wb_dat_i[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Ceiling selection and clamp
  // ----------------------------------------------------------
  torque_ceiling_select u_sel (
    .ref_clk(ref_clk),
    .rst(rst),
    .fwd_ceil(forward_torque_ceiling_q),
    .rev_ceil(reverse_torque_ceiling_q),
    .int_ceil(internal_torque_ceiling_q),
    .ana_gain(analog_torque_gain_q),
    .ana_en(analog_limit_enable_q),
    .fwd_clamp(forward_clamp_input),
    .rev_clamp(reverse_clamp_input),
    .analog_level(analog_level),
    .fwd_limit_q(fwd_limit),
    .rev_limit_q(rev_limit)
  );

  // Signed request magnitude against direction ceiling
  reg [15:0] req_mag;
  reg fwd_hit;
  reg rev_hit;
  reg [15:0] cmd_d;
  always @* begin
    req_mag = torque_request[15] ? (~torque_request + 16'h0001) : torque_request;
    fwd_hit = ~torque_request[15] & (req_mag > fwd_limit);
    rev_hit = torque_request[15] & (req_mag > rev_limit);
    if (fwd_hit) begin
      cmd_d = fwd_limit;
    end else if (rev_hit) begin
      cmd_d = ~rev_limit + 16'h0001;
    end else begin
      cmd_d = torque_request;
    end
  end

  // Clamped command and limited flag
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      torque_command_q <= 16'h0000;
      torque_limited_output <= 1'b0;
    end else begin
      torque_command_q <= cmd_d;
      torque_limited_output <= fwd_hit | rev_hit;
    end
  end

  // ----------------------------------------------------------
  // Mode decode and pulse command
  // ----------------------------------------------------------
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulse_mode_q <= 1'b0;
      int_pos_mode_q <= 1'b0;
    end else begin
      pulse_mode_q <= (control_mode_select_q == `MODE_PULSE);
      int_pos_mode_q <= (control_mode_select_q == `MODE_INTPOS);
    end
  end

  pulse_cmd_sum u_sum (
    .ref_clk(ref_clk),
    .rst(rst),
    .pulse_source_select(pulse_source_select_q),
    .low_pulse_count(low_pulse_count),
    .high_pulse_count(high_pulse_count),
    .int_pulse_count(int_pulse_count),
    .pulse_cmd_q(pulse_cmd)
  );

  // ----------------------------------------------------------
  // Interrupt status, set wins over clear
  // ----------------------------------------------------------
  wire [2:0] ev;
  wire [2:0] clr;
  wire mode_entry = pulse_mode_q & ~mode_prev_q; // Rising edge of pulse mode
  assign ev = {mode_entry, rev_hit, fwd_hit};
  assign clr = (wr_en && wb_adr_i == `OFS_IRQ_CLR && wb_sel_i[0]) ? wb_dat_i[2:0] : 3'h0;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= 3'h0;
      mode_prev_q <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~clr) | ev;
      mode_prev_q <= pulse_mode_q;
    end
  end
  assign irq = |(irq_stat_q & irq_en_q);

  // ----------------------------------------------------------
  // Read data and ack
  // ----------------------------------------------------------
  // Read word of the addressed register
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h00000000;
    case (wb_adr_i)
      `OFS_FWD_CEIL: begin
        rd_word = zext16(forward_torque_ceiling_q);
      end
      `OFS_REV_CEIL: begin
        rd_word = zext16(reverse_torque_ceiling_q);
      end
      `OFS_ANA_EN: begin
        rd_word = {31'h0, analog_limit_enable_q};
      end
      `OFS_BAND: begin
        rd_word = zext16(target_torque_band_q);
      end
      `OFS_FILT: begin
        rd_word = zext16(torque_filter_freq_q);
      end
      `OFS_INT_CEIL: begin
        rd_word = zext16(internal_torque_ceiling_q);
      end
      `OFS_ANA_GAIN: begin
        rd_word = zext16(analog_torque_gain_q);
      end
      `OFS_MODE: begin
        rd_word = {28'h0, control_mode_select_q};
      end
      `OFS_PSRC: begin
        rd_word = {29'h0, pulse_source_select_q};
      end
      `OFS_STATUS: begin
        rd_word = {29'h0, irq_stat_q};
      end
      `OFS_IRQ_EN: begin
        rd_word = {29'h0, irq_en_q};
      end
      `OFS_LIVE: begin
        rd_word = {rev_limit, fwd_limit};
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // Registered read data and one-cycle ack
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req_new;
      if (rd_en) begin
        wb_dat_o <= rd_word;
      end
    end
  end

endmodule

// ### rtl/torque_limit_regs.vh
`ifndef TORQUE_LIMIT_REGS_VH
`define TORQUE_LIMIT_REGS_VH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define OFS_FWD_CEIL 6'h00
`define OFS_REV_CEIL 6'h04
`define OFS_ANA_EN 6'h08
`define OFS_BAND 6'h0c
`define OFS_FILT 6'h10
`define OFS_INT_CEIL 6'h14
`define OFS_ANA_GAIN 6'h18
`define OFS_MODE 6'h1c
`define OFS_PSRC 6'h20
`define OFS_STATUS 6'h24
`define OFS_IRQ_EN 6'h28
`define OFS_IRQ_CLR 6'h2c
`define OFS_LIVE 6'h30

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define RST_FWD_CEIL 16'h0064
`define RST_REV_CEIL 16'h0064
`define RST_BAND 16'h0002
`define RST_FILT 16'h000a
`define RST_INT_CEIL 16'h00c8
`define RST_GAIN 16'h0100
`define CEIL_MAX 16'h0320
`define FILT_MIN 16'h0001
`define FILT_MAX 16'h03e8
`define MODE_PULSE 4'h1
`define MODE_INTPOS 4'h5

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PSRC_LOW 0
`define PSRC_HIGH 1
`define PSRC_INT 2
`define ST_FWD 0
`define ST_REV 1
`define ST_MODE 2

`endif

// ### rtl/torque_ceiling_select.v
`timescale 1ns/1ps
`include "torque_limit_regs.vh"
module torque_ceiling_select (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Ceilings
  input wire [15:0] fwd_ceil,
  input wire [15:0] rev_ceil,
  input wire [15:0] int_ceil,
  input wire [15:0] ana_gain,
  input wire ana_en,
  input wire fwd_clamp,
  input wire rev_clamp,
  // Analog level, signed
  input wire [15:0] analog_level,
  // Results
  output reg [15:0] fwd_limit_q,
  output reg [15:0] rev_limit_q
);

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function [15:0] min16;
    input [15:0] a;
    input [15:0] b;
    begin
      min16 = (a < b) ? a : b;
    end
  endfunction

  reg [15:0] mag;
  reg [31:0] prod;
  reg [15:0] ana_ceil;
  reg [15:0] fwd_d;
  reg [15:0] rev_d;

  // Analog magnitude, gain in 1/256 steps, saturated
  always @* begin
    mag = analog_level[15] ? (~analog_level + 16'h0001) : analog_level;
    prod = mag * ana_gain;
    ana_ceil = (prod[31:24] != 8'h00) ? 16'hffff : prod[23:8];
    fwd_d = min16(int_ceil, `CEIL_MAX);
    rev_d = fwd_d;
    if (fwd_clamp) begin
      fwd_d = min16(fwd_d, fwd_ceil);
    end
    if (rev_clamp) begin
      rev_d = min16(rev_d, rev_ceil);
    end
    if (ana_en) begin
      fwd_d = min16(fwd_d, ana_ceil);
      rev_d = min16(rev_d, ana_ceil);
    end
  end

  // Registered ceilings
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fwd_limit_q <= 16'h0000;
      rev_limit_q <= 16'h0000;
    end else begin
      fwd_limit_q <= fwd_d;
      rev_limit_q <= rev_d;
    end
  end

endmodule

// ### rtl/pulse_cmd_sum.v
`timescale 1ns/1ps
`include "torque_limit_regs.vh"
module pulse_cmd_sum (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Source select and counts
  input wire [2:0] pulse_source_select,
  input wire [15:0] low_pulse_count,
  input wire [15:0] high_pulse_count,
  input wire [15:0] int_pulse_count,
  // Effective command
  output reg [15:0] pulse_cmd_q
);

  reg [15:0] sum_d;

  // Sum of every enabled source
  always @* begin
    sum_d = 16'h0000;
    if (pulse_source_select[`PSRC_LOW]) begin
      sum_d = sum_d + low_pulse_count;
    end
    if (pulse_source_select[`PSRC_HIGH]) begin
      sum_d = sum_d + high_pulse_count;
    end
    if (pulse_source_select[`PSRC_INT]) begin
      sum_d = sum_d + int_pulse_count;
    end
  end

  // Registered effective command
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pulse_cmd_q <= 16'h0000;
    end else begin
      pulse_cmd_q <= sum_d;
    end
  end

endmodule

// ### sim/host_terminals.sv
`timescale 1ns/1ps
module host_terminals (
  // Clock
  input wire ref_clk,
  // Terminals toward the drive
  output logic forward_clamp_input,
  output logic reverse_clamp_input,
  output logic [15:0] analog_level
);
  // ----------------------------------------
  // Terminal drive
  // ----------------------------------------
  // Idle terminals at power up
  initial begin
    forward_clamp_input = 1'b0;
    reverse_clamp_input = 1'b0;
    analog_level = 16'h0000;
  end

  // One terminal per clamp direction, moved just after an edge
  task drive(input logic f, input logic rv, input logic [15:0] lvl);
    @(posedge ref_clk);
    forward_clamp_input <= f;
    reverse_clamp_input <= rv;
    analog_level <= lvl;
  endtask
endmodule

// ### sim/torque_limit_checker.sv
`timescale 1ns/1ps
module torque_limit_checker (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Bus handshake
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // Torque path
  input wire [15:0] torque_request,
  input wire [15:0] torque_command_q,
  input wire [15:0] fwd_limit,
  input wire [15:0] rev_limit,
  input wire torque_limited_output
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Over-limit detection
  // ----------------------------------------
  // Request beyond either current ceiling
  wire signed [17:0] r = $signed(torque_request);
  wire of = r > $signed({2'b0, fwd_limit});
  wire orv = -r > $signed({2'b0, rev_limit});

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_fwd_clamp_value: assert property (of |=> torque_command_q == $past(fwd_limit))
    else $error("forward clamp value wrong");
  a_rev_clamp_value: assert property (orv |=> torque_command_q == 16'h0 - $past(rev_limit))
    else $error("reverse clamp value wrong");
  a_pass_through: assert property (!of && !orv |=> torque_command_q == $past(torque_request))
    else $error("unclamped request altered");
  a_limited_flag: assert property (1'b1 |=> torque_limited_output == $past(of || orv))
    else $error("limited flag wrong");
  a_fwd_ceiling_cap: assert property (fwd_limit <= 16'h0320)
    else $error("forward limit above max");
  a_rev_ceiling_cap: assert property (rev_limit <= 16'h0320)
    else $error("reverse limit above max");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
endmodule

bind servo_torque_limit_select torque_limit_checker u_torque_limit_checker (
  .ref_clk(ref_clk),
  .rst(rst),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .torque_request(torque_request),
  .torque_command_q(torque_command_q),
  .fwd_limit(fwd_limit),
  .rev_limit(rev_limit),
  .torque_limited_output(torque_limited_output)
);

// ### sim/tb_servo_torque_limit_select.sv
`timescale 1ns/1ps
`include "torque_limit_regs.vh"
module tb_servo_torque_limit_select;
  logic ref_clk, rst, cyc, stb, we;
  logic [5:0] adr;
  logic [3:0] sel = 4'hf;
  logic [31:0] dwr, q;
  logic [15:0] req, lo, hi, ip;
  wire [31:0] rdat;
  wire ack, fcl, rcl, lim, pm, ipm, irq;
  wire [15:0] lvl, cmd, fl, rl, pc;
  int errors, comparisons;

  // ----------------------------------------
  // Design and host
  // ----------------------------------------
  servo_torque_limit_select u_servo_torque_limit_select (
    .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(rdat), .wb_ack_o(ack),
    .forward_clamp_input(fcl), .reverse_clamp_input(rcl), .analog_level(lvl),
    .torque_limited_output(lim), .torque_request(req), .torque_command_q(cmd),
    .fwd_limit(fl), .rev_limit(rl), .low_pulse_count(lo), .high_pulse_count(hi),
    .int_pulse_count(ip), .pulse_cmd(pc), .pulse_mode_q(pm), .int_pos_mode_q(ipm), .irq(irq));
  host_terminals u_host_terminals (.ref_clk(ref_clk), .forward_clamp_input(fcl),
    .reverse_clamp_input(rcl), .analog_level(lvl));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask

  // One classic bus cycle, held until ack
  task wb(input logic [5:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dwr <= d;
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1); // Only the watchdog ends a hang
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task set_req(input logic [15:0] v);
    @(posedge ref_clk);
    req <= v;
    step(3);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    logic [31:0] ex [6] = '{32'h64, 32'h64, 32'h0, 32'h2, 32'ha, 32'hc8};
    for (int i = 0; i < 6; i++) begin
      wb(6'(i * 4), 1'b0, 32'h0);
      chk("reset value", ex[i], q);
    end
    wb(6'h3c, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("reset test done");
  endtask

  task t_fwd;
    u_host_terminals.drive(1'b1, 1'b0, 16'h0);
    set_req(16'd300);
    chk("fwd cmd", 16'd100, cmd);
    chk("flag", 1'b1, lim);
    u_host_terminals.drive(1'b0, 1'b0, 16'h0);
    step(3);
    chk("internal cmd", 16'd200, cmd);
    wb(`OFS_INT_CEIL, 1'b1, 32'h50);
    step(3);
    chk("min cmd", 16'h50, cmd);
    wb(`OFS_LIVE, 1'b0, 32'h0);
    chk("live", 32'h00500050, q);
    wb(`OFS_INT_CEIL, 1'b1, 32'hc8);
    set_req(16'd150);
    chk("pass cmd", 16'd150, cmd);
    chk("flag", 1'b0, lim);
    $display("forward test done");
  endtask

  task t_rev;
    wb(`OFS_REV_CEIL, 1'b1, 32'h384);
    wb(`OFS_REV_CEIL, 1'b0, 32'h0);
    chk("rev clip", 32'h320, q);
    wb(`OFS_REV_CEIL, 1'b1, 32'h32);
    u_host_terminals.drive(1'b0, 1'b1, 16'h0);
    set_req(16'hff88);
    chk("rev cmd", 16'hffce, cmd);
    chk("flag", 1'b1, lim);
    u_host_terminals.drive(1'b0, 1'b0, 16'h0);
    step(3);
    chk("rev off", 16'hff88, cmd);
    $display("reverse test done");
  endtask

  task t_ana;
    u_host_terminals.drive(1'b0, 1'b0, 16'hffc0);
    set_req(16'd100);
    chk("ana off", 16'd100, cmd);
    wb(`OFS_ANA_EN, 1'b1, 32'h1);
    step(3);
    chk("ana fwd", 16'h40, cmd);
    set_req(16'hff9c);
    chk("ana rev", 16'hffc0, cmd);
    wb(`OFS_ANA_GAIN, 1'b1, 32'h200);
    set_req(16'hff00); // Beyond the doubled ceiling of 128
    chk("ana gain", 16'hff80, cmd);
    wb(`OFS_ANA_EN, 1'b1, 32'h0);
    u_host_terminals.drive(1'b0, 1'b0, 16'h0);
    $display("analog test done");
  endtask

  task t_pulse;
    wb(`OFS_FILT, 1'b1, 32'h0);
    wb(`OFS_FILT, 1'b0, 32'h0);
    chk("filt low", 32'h1, q);
    wb(`OFS_FILT, 1'b1, 32'h7d0);
    wb(`OFS_FILT, 1'b0, 32'h0);
    chk("filt high", 32'h3e8, q);
    wb(`OFS_MODE, 1'b1, 32'h1);
    step(2);
    chk("pulse mode", 2'b10, {pm, ipm});
    wb(`OFS_STATUS, 1'b0, 32'h0);
    chk("mode event", 32'h4, q & 32'h4);
    wb(`OFS_MODE, 1'b1, 32'h5);
    step(2);
    chk("int mode", 2'b01, {pm, ipm});
    @(posedge ref_clk);
    lo <= 16'd3;
    hi <= 16'd7;
    ip <= 16'd5;
    wb(`OFS_PSRC, 1'b1, 32'h5);
    step(2);
    chk("pulse sum", 16'd8, pc);
    $display("pulse test done");
  endtask

  task t_irq;
    wb(`OFS_IRQ_EN, 1'b1, 32'h0);
    wb(`OFS_IRQ_CLR, 1'b1, 32'h7);
    u_host_terminals.drive(1'b1, 1'b0, 16'h0);
    set_req(16'd300);
    u_host_terminals.drive(1'b0, 1'b0, 16'h0);
    set_req(16'd0);
    wb(`OFS_STATUS, 1'b0, 32'h0);
    chk("status", 32'h3, q);
    chk("irq masked", 1'b0, irq);
    wb(`OFS_IRQ_EN, 1'b1, 32'h1);
    step(1);
    chk("irq on", 1'b1, irq);
    wb(`OFS_IRQ_CLR, 1'b1, 32'h1);
    step(1);
    chk("irq clear", 1'b0, irq);
    wb(`OFS_IRQ_CLR, 1'b0, 32'h0);
    chk("clr read", 32'h0, q);
    $display("irq test done");
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task give_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    give_verdict;
  end

  initial begin
    rst = 1'b1;
    {cyc, stb, we, adr, dwr, req, lo, hi, ip} = '0;
    errors = 0;
    comparisons = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_fwd;
    t_rev;
    t_ana;
    t_pulse;
    t_irq;
    give_verdict;
  end
endmodule
